// ==== design/arr_pkg.sv ====
// Shared constants for the converter result serial readout link.
package arr_pkg;

   // ************************************************************
   // Frame shape
   // ************************************************************
   localparam int unsigned BYTE_BITS = 8;
   localparam int unsigned READ_BYTES = 3;
   localparam int unsigned WORD_BITS = BYTE_BITS * READ_BYTES;
   localparam int unsigned CFG_BITS = 4;
   localparam int unsigned CODE_BITS = 18;
   localparam int unsigned BIT_CNT_W = 5;
   localparam logic [BIT_CNT_W-1:0] WORD_CNT = 5'h18;
   localparam logic [BIT_CNT_W-1:0] LAST_BIT = 5'h17;
   localparam logic [BIT_CNT_W-1:0] BIT_CNT_RESET = 5'h00;

   // ************************************************************
   // Field positions inside the 24-bit frame
   // ************************************************************
   localparam int unsigned CFG_BYTE_LSB = 16;
   localparam int unsigned SPEED_POS = 15;
   localparam int unsigned CFG_NIB_LSB = 16;
   localparam int unsigned CODE_LSB = 4;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [3:0] CFG_PREV_RESET = 4'h0;
   localparam logic [31:0] SIGN_OFFSET = 32'h00200000;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int unsigned CLK_NS = 20;
   localparam int unsigned SCLK_HALF_NS = 160;
   localparam int unsigned SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned HALF_CNT_W = 8;
   localparam int unsigned CONV_PERIOD_US = 200000;
   localparam int unsigned CONV_TIMEOUT_CYC = CONV_PERIOD_US * (1000 / CLK_NS);
   localparam int unsigned TMO_CNT_W = 32;

endpackage : arr_pkg

// ==== design/arr_link_if.sv ====
// Serial link between the readout host and the converter's result port.
`timescale 1ns/1ps
`default_nettype none
interface arr_link_if;
   logic cs_n;
   logic sclk;
   logic mosi;
   logic result_output_line;
   logic result_output_en;
   logic miso;

   // The line floats high through a pull-up while the device does not drive it.
   assign miso = result_output_en ? result_output_line : 1'b1;

   modport dev (
      input cs_n,
      input sclk,
      input mosi,
      output result_output_line,
      output result_output_en
   );

   modport host (
      output cs_n,
      output sclk,
      output mosi,
      input miso
   );
endinterface : arr_link_if
`default_nettype wire

// ==== design/arr_device.sv ====
// Device end: presents conversion results on the serial result line.
`timescale 1ns/1ps
`default_nettype none
module arr_device #(
   parameter int unsigned CODE_W = arr_pkg::CODE_BITS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   arr_link_if.dev link,
   input wire logic code_valid,
   output logic code_ready,
   input wire logic [CODE_W-1:0] code_data,
   output logic cfg_valid,
   output logic [7:0] cfg_data,
   output logic speed_sel,
   output logic conv_busy
);
   localparam int unsigned WORD_W = 2 + CODE_W + arr_pkg::CFG_BITS;

   typedef enum logic [1:0] {ARR_DS_IDLE, ARR_DS_WAIT, ARR_DS_SHIFT} arr_dev_state_t;

   typedef struct packed {
      arr_dev_state_t st;
      logic cs1;
      logic cs2;
      logic ck1;
      logic ck2;
      logic ck3;
      logic mo1;
      logic mo2;
      logic [1:0][CODE_W-1:0] mem;
      logic wr_ptr;
      logic rd_ptr;
      logic [1:0] count;
      logic [WORD_W-1:0] tx;
      logic [WORD_W-1:0] rx;
      logic [arr_pkg::BIT_CNT_W-1:0] nbits;
      logic line;
      logic line_en;
      logic [3:0] cfg_prev;
      logic [7:0] cfg;
      logic speed;
      logic cfg_valid;
   } arr_dev_s_t;

   localparam arr_dev_s_t S_RST = '{st: ARR_DS_IDLE, cs1: 1'b1, cs2: 1'b1, line: 1'b1,
                                    cfg: arr_pkg::CFG_RESET, cfg_prev: arr_pkg::CFG_PREV_RESET,
                                    nbits: arr_pkg::BIT_CNT_RESET, default: '0};

   arr_dev_s_t s;
   arr_dev_s_t next_s;
   logic push;
   logic pop;
   logic rise;
   logic fall;

   // ************************************************************
   // Next state
   // ************************************************************
   assign code_ready = (s.count != 2'h2);
   assign push = code_valid && code_ready;
   assign rise = s.ck2 && !s.ck3;
   assign fall = !s.ck2 && s.ck3;

   always_comb begin
      next_s = s;
      pop = 1'b0;
      next_s.cfg_valid = 1'b0;
      next_s.cs1 = link.cs_n;
      next_s.cs2 = s.cs1;
      next_s.ck1 = link.sclk;
      next_s.ck2 = s.ck1;
      next_s.ck3 = s.ck2;
      next_s.mo1 = link.mosi;
      next_s.mo2 = s.mo1;
      case (s.st)
         ARR_DS_IDLE: begin
            next_s.line = 1'b1;
            next_s.line_en = 1'b0;
            if (!s.cs2) begin
               next_s.line_en = 1'b1;
               next_s.st = ARR_DS_WAIT;
            end
         end
         ARR_DS_WAIT: begin
            if (s.cs2) begin
               next_s.line_en = 1'b0;
               next_s.st = ARR_DS_IDLE;
            end else if (s.count != 2'h0) begin
               pop = 1'b1;
               next_s.tx = {2'b00, s.mem[s.rd_ptr], s.cfg_prev};
               next_s.line = 1'b0;
               next_s.nbits = arr_pkg::BIT_CNT_RESET;
               next_s.st = ARR_DS_SHIFT;
            end else begin
               next_s.line = 1'b1;
            end
         end
         ARR_DS_SHIFT: begin
            if (s.cs2) begin
               next_s.line = 1'b1;
               next_s.line_en = 1'b0;
               next_s.st = ARR_DS_IDLE;
               // A frame cut short leaves the next conversion's setup untouched.
               if (s.nbits == arr_pkg::WORD_CNT) begin
                  next_s.cfg = s.rx[arr_pkg::CFG_BYTE_LSB +: 8];
                  next_s.speed = s.rx[arr_pkg::SPEED_POS];
                  next_s.cfg_prev = s.rx[arr_pkg::CFG_NIB_LSB +: arr_pkg::CFG_BITS];
                  next_s.cfg_valid = 1'b1;
               end
            end else begin
               if (rise && s.nbits != arr_pkg::WORD_CNT) begin
                  next_s.rx = {s.rx[WORD_W-2:0], s.mo2};
                  next_s.nbits = 5'(s.nbits + 5'h1);
               end
               if (fall) begin
                  next_s.tx = {s.tx[WORD_W-2:0], 1'b0};
                  next_s.line = s.tx[WORD_W-2];
               end
            end
         end
         default: begin
            next_s.st = ARR_DS_IDLE;
         end
      endcase

      // ************************************************************
      // Two-entry result buffer
      // ************************************************************
      if (push) begin
         next_s.mem[s.wr_ptr] = code_data;
         next_s.wr_ptr = ~s.wr_ptr;
      end
      if (pop) begin
         next_s.rd_ptr = ~s.rd_ptr;
      end
      case ({push, pop})
         2'b10: next_s.count = 2'(s.count + 2'h1);
         2'b01: next_s.count = 2'(s.count - 2'h1);
         default: next_s.count = s.count;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= S_RST;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign link.result_output_line = s.line;
   assign link.result_output_en = s.line_en;
   assign cfg_valid = s.cfg_valid;
   assign cfg_data = s.cfg;
   assign speed_sel = s.speed;
   assign conv_busy = (s.count == 2'h0);
endmodule : arr_device
`default_nettype wire

// ==== design/arr_host.sv ====
// Host end: selects the converter, waits for a result and reads three bytes.
`timescale 1ns/1ps
`default_nettype none
module arr_host #(
   parameter int unsigned TIMEOUT_CYC = arr_pkg::CONV_TIMEOUT_CYC,
   parameter int unsigned HALF_CYC = arr_pkg::SCLK_HALF_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   arr_link_if.host link,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [7:0] req_cfg,
   input wire logic req_speed,
   output logic mux_switch,
   output logic res_valid,
   output logic res_timeout,
   output logic [arr_pkg::WORD_BITS-1:0] res_raw,
   output logic [3:0] res_cfg,
   output logic [31:0] res_signed
);
   localparam int unsigned WORD_W = arr_pkg::WORD_BITS;
   localparam logic [arr_pkg::HALF_CNT_W-1:0] HALF_LAST = arr_pkg::HALF_CNT_W'(HALF_CYC - 1);
   localparam logic [arr_pkg::TMO_CNT_W-1:0] TMO_LAST = arr_pkg::TMO_CNT_W'(TIMEOUT_CYC - 1);

   typedef enum logic [2:0] {
      ARR_HS_IDLE,
      ARR_HS_WAIT,
      ARR_HS_SHIFT,
      ARR_HS_TAIL,
      ARR_HS_CLOSE,
      ARR_HS_GUARD
   } arr_host_state_t;

   typedef struct packed {
      arr_host_state_t st;
      logic mi1;
      logic mi2;
      logic cs_n;
      logic sclk;
      logic mosi;
      logic [WORD_W-1:0] tx;
      logic [WORD_W-1:0] rx;
      logic [arr_pkg::BIT_CNT_W-1:0] nbits;
      logic [arr_pkg::HALF_CNT_W-1:0] div;
      logic [arr_pkg::TMO_CNT_W-1:0] tmo;
      logic mux_switch;
      logic res_valid;
      logic res_timeout;
      logic [WORD_W-1:0] res_raw;
      logic [31:0] res_signed;
   } arr_host_s_t;

   localparam arr_host_s_t S_RST = '{st: ARR_HS_IDLE, mi1: 1'b1, mi2: 1'b1, cs_n: 1'b1,
                                     nbits: arr_pkg::BIT_CNT_RESET, default: '0};

   arr_host_s_t s;
   arr_host_s_t next_s;
   logic half_done;
   logic [31:0] masked;

   assign half_done = (s.div == HALF_LAST);
   assign req_ready = (s.st == ARR_HS_IDLE);

   // ************************************************************
   // Result conversion
   // ************************************************************
   // The sign offset is applied to the raw frame with its setup nibble cleared,
   // so the converter's top bit lands at weight 2^21 of a 32-bit signed value.
   // clear and subtract
   assign masked = {8'h00, s.rx[WORD_W-1:arr_pkg::CODE_LSB], 4'h0};

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      next_s = s;
      next_s.mi1 = link.miso;
      next_s.mi2 = s.mi1;
      next_s.mux_switch = 1'b0;
      next_s.res_valid = 1'b0;
      next_s.div = half_done ? '0 : arr_pkg::HALF_CNT_W'(s.div + 1'b1);
      case (s.st)
         ARR_HS_IDLE: begin
            next_s.div = '0;
            if (req_valid) begin
               next_s.cs_n = 1'b0;
               next_s.tx = {req_cfg, req_speed, 7'h00, 8'h00};
               next_s.mosi = req_cfg[7];
               next_s.tmo = '0;
               next_s.res_timeout = 1'b0;
               next_s.st = ARR_HS_WAIT;
            end
         end
         ARR_HS_WAIT: begin
            next_s.div = '0;
            if (!s.mi2) begin
               next_s.mux_switch = 1'b1;
               next_s.nbits = arr_pkg::BIT_CNT_RESET;
               next_s.st = ARR_HS_SHIFT;
            end else if (s.tmo == TMO_LAST) begin
               next_s.cs_n = 1'b1;
               next_s.res_timeout = 1'b1;
               next_s.res_valid = 1'b1;
               next_s.st = ARR_HS_GUARD;
            end else begin
               next_s.tmo = arr_pkg::TMO_CNT_W'(s.tmo + 1'b1);
            end
         end
         ARR_HS_SHIFT: begin
            if (half_done) begin
               if (!s.sclk) begin
                  next_s.sclk = 1'b1;
                  next_s.rx = {s.rx[WORD_W-2:0], s.mi2};
                  next_s.nbits = 5'(s.nbits + 5'h1);
                  if (s.nbits == arr_pkg::LAST_BIT) begin
                     next_s.st = ARR_HS_TAIL;
                  end
               end else begin
                  next_s.sclk = 1'b0;
                  next_s.tx = {s.tx[WORD_W-2:0], 1'b0};
                  next_s.mosi = s.tx[WORD_W-2];
               end
            end
         end
         ARR_HS_TAIL: begin
            if (half_done) begin
               next_s.sclk = 1'b0;
               next_s.mosi = 1'b0;
               next_s.st = ARR_HS_CLOSE;
            end
         end
         ARR_HS_CLOSE: begin
            if (half_done) begin
               next_s.cs_n = 1'b1;
               next_s.res_valid = 1'b1;
               next_s.res_raw = s.rx;
               next_s.res_signed = masked - arr_pkg::SIGN_OFFSET;
               next_s.st = ARR_HS_GUARD;
            end
         end
         ARR_HS_GUARD: begin
            // Keeps the select high long enough for the device to release the
            // line, so the next wait cannot mistake a stale low for a result.
            if (half_done) begin
               next_s.st = ARR_HS_IDLE;
            end
         end
         default: begin
            next_s.st = ARR_HS_IDLE;
         end
      endcase
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= S_RST;
      end else if (ce) begin
         s <= next_s;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign link.cs_n = s.cs_n;
   assign link.sclk = s.sclk;
   assign link.mosi = s.mosi;
   assign mux_switch = s.mux_switch;
   assign res_valid = s.res_valid;
   assign res_timeout = s.res_timeout;
   assign res_raw = s.res_raw;
   assign res_cfg = s.res_raw[arr_pkg::CFG_BITS-1:0];
   assign res_signed = s.res_signed;
endmodule : arr_host
`default_nettype wire

// ==== bench/arr_link_chk.sv ====
// Concurrent checks on the serial link between the host and device ends.
`timescale 1ns/1ps
`default_nettype none
module arr_link_chk #(
   parameter int TMO_MAX = 260
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic result_output_line,
   input wire logic result_output_en,
   input wire logic miso
);
   // ************************************************************
   // Rising edges of the link clock within one selection
   // ************************************************************
   logic sclk_d;
   logic [5:0] rises;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sclk_d <= 1'b0;
         rises <= 6'h00;
      end else begin
         sclk_d <= sclk;
         if (cs_n) begin
            rises <= 6'h00;
         end else if (sclk && !sclk_d) begin
            rises <= rises + 6'h01;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_mosi_hold;
      !cs_n && $changed(mosi) |-> !sclk;
   endproperty
   a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved while sclk high");

   property p_line_hold;
      $changed(result_output_line) |-> !sclk;
   endproperty
   a_line_hold: assert property (p_line_hold) else $error("result line moved while sclk high");

   property p_idle_low;
      cs_n |-> !sclk;
   endproperty
   a_idle_low: assert property (p_idle_low) else $error("sclk high while deselected");

   property p_half;
      $rose(sclk) |-> sclk [*8] ##1 !sclk;
   endproperty
   a_half: assert property (p_half) else $error("sclk high phase not eight cycles");

   property p_ready_low;
      $rose(sclk) && rises == 6'h00 |-> !miso;
   endproperty
   a_ready_low: assert property (p_ready_low) else $error("clocking began without ready low");

   property p_wait;
      $fell(cs_n) |-> ##[1:TMO_MAX] (cs_n || !miso);
   endproperty
   a_wait: assert property (p_wait) else $error("select held too long without result");

   property p_count;
      $rose(cs_n) |-> rises == 6'h18 || rises == 6'h00;
   endproperty
   a_count: assert property (p_count) else $error("frame not three whole bytes");

   property p_max;
      rises <= 6'h18;
   endproperty
   a_max: assert property (p_max) else $error("more than 24 clock rises");

   property p_release;
      cs_n [*6] |-> !result_output_en;
   endproperty
   a_release: assert property (p_release) else $error("line driven while deselected");

   property p_drop;
      $fell(result_output_en) |-> cs_n;
   endproperty
   a_drop: assert property (p_drop) else $error("line released while selected");
endmodule : arr_link_chk
`default_nettype wire

// ==== bench/adc_result_serial_readout_test.sv ====
// Self-checking bench joining the host and device ends over one link.
`timescale 1ns/1ps
`default_nettype none
module adc_result_serial_readout_test;
   localparam int TMO = 200;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic code_valid, code_ready, cfg_valid, speed_sel, conv_busy;
   logic req_valid, req_ready, req_speed, mux_switch, res_valid, res_timeout;
   logic [17:0] code_data;
   logic [7:0] cfg_data, req_cfg;
   logic [23:0] res_raw, rx_sh, tx_sh;
   logic [3:0] res_cfg, prev;
   logic [31:0] res_signed, c;
   int err_total = 0;
   int n_tests = 0;
   int cfg_cnt = 0;
   int mux_cnt = 0;
   integer seed;

   arr_link_if arr_link_if_i ();
   arr_device arr_device_i (.clk(clk), .rst(rst), .ce(ce), .link(arr_link_if_i.dev),
      .code_valid(code_valid), .code_ready(code_ready), .code_data(code_data), .cfg_valid(cfg_valid),
      .cfg_data(cfg_data), .speed_sel(speed_sel), .conv_busy(conv_busy));
   arr_host #(.TIMEOUT_CYC(TMO), .HALF_CYC(8)) arr_host_i (.clk(clk), .rst(rst), .ce(ce),
      .link(arr_link_if_i.host), .req_valid(req_valid), .req_ready(req_ready), .req_cfg(req_cfg),
      .req_speed(req_speed), .mux_switch(mux_switch), .res_valid(res_valid), .res_timeout(res_timeout),
      .res_raw(res_raw), .res_cfg(res_cfg), .res_signed(res_signed));
   arr_link_chk #(.TMO_MAX(TMO + 60)) arr_link_chk_i (.clk(clk), .rst(rst), .cs_n(arr_link_if_i.cs_n),
      .sclk(arr_link_if_i.sclk), .mosi(arr_link_if_i.mosi), .miso(arr_link_if_i.miso),
      .result_output_line(arr_link_if_i.result_output_line), .result_output_en(arr_link_if_i.result_output_en));

   always #10 clk = ~clk;

   // Both directions are captured on the rising link clock, where the data must be settled.
   always @(posedge arr_link_if_i.sclk) begin
      if (!arr_link_if_i.cs_n) begin
         rx_sh <= {rx_sh[22:0], arr_link_if_i.miso};
         tx_sh <= {tx_sh[22:0], arr_link_if_i.mosi};
      end
   end

   always @(posedge clk) begin
      if (cfg_valid === 1'b1) cfg_cnt <= cfg_cnt + 1;
      if (mux_switch === 1'b1) mux_cnt <= mux_cnt + 1;
   end

   function automatic logic [23:0] exp_raw(input logic [17:0] code, input logic [3:0] cfg_prev);
      return {2'b00, code, cfg_prev};
   endfunction : exp_raw

   function automatic logic [31:0] exp_signed(input logic [23:0] raw);
      return {8'h00, raw[23:4], 4'h0} - 32'h00200000;
   endfunction : exp_signed

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish

   task automatic push(input logic [17:0] d);
      @(negedge clk);
      code_valid = 1'b1;
      code_data = d;
      while (code_ready !== 1'b1) @(negedge clk);
      @(negedge clk);
      code_valid = 1'b0;
   endtask : push

   task automatic frame(input logic [7:0] cfg, input logic spd, input logic [17:0] code, input logic tmo);
      logic [23:0] raw;
      int c0;
      int m0;
      int i;
      raw = exp_raw(code, prev);
      c0 = cfg_cnt;
      m0 = mux_cnt;
      @(negedge clk);
      req_valid = 1'b1;
      req_cfg = cfg;
      req_speed = spd;
      while (req_ready !== 1'b1) @(negedge clk);
      @(negedge clk);
      req_valid = 1'b0;
      for (i = 0; i < 3000 && res_valid !== 1'b1; i++) @(negedge clk);
      check(32'(i < 3000), 32'h1);
      check(32'(res_timeout), 32'(tmo));
      // A timed-out wait must have lasted the full limit, not ended early.
      if (tmo) begin
         check(32'(i >= TMO && i <= TMO + 4), 32'h1);
      end
      // Past the guard time the device has seen the deselect and, unless the wait timed out, published the new setting.
      repeat (12) @(negedge clk);
      check(32'(mux_cnt - m0), 32'(!tmo));
      check(32'(cfg_cnt - c0), 32'(!tmo));
      if (!tmo) begin
         check(32'(res_raw), 32'(raw));
         check(32'(rx_sh), 32'(raw));
         check(32'(tx_sh), 32'({cfg, spd, 15'h0000}));
         check(32'(res_cfg), 32'(prev));
         check(res_signed, exp_signed(raw));
         check(32'(cfg_data), 32'(cfg));
         check(32'(speed_sel), 32'(spd));
         prev = cfg[3:0];
      end
   endtask : frame

   initial begin
      seed = 32'hfbb7;
      code_valid = 1'b0;
      code_data = 18'h00000;
      req_valid = 1'b0;
      req_cfg = 8'h00;
      req_speed = 1'b0;
      prev = 4'h0;
      repeat (8) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      check(32'(arr_link_if_i.cs_n), 32'h1);
      check(32'(arr_link_if_i.sclk), 32'h0);
      check(32'({code_ready, conv_busy, req_ready}), 32'h7);
      // Clock enable low freezes both ends, so neither the push nor the request may be taken.
      ce = 1'b0;
      push(18'h15555);
      req_valid = 1'b1;
      repeat (4) @(negedge clk);
      req_valid = 1'b0;
      check(32'({conv_busy, arr_link_if_i.cs_n}), 32'h3);
      ce = 1'b1;
      // An empty buffer keeps the line high, so the host must give up.
      frame(8'ha5, 1'b1, 18'h00000, 1'b1);
      push(18'h3ffff);
      push(18'h00000);
      check(32'({code_ready, conv_busy}), 32'h0);
      frame(8'hff, 1'b1, 18'h3ffff, 1'b0);
      frame(8'h00, 1'b0, 18'h00000, 1'b0);
      repeat (6) begin
         c = $random(seed);
         push(c[17:0]);
         frame(c[25:18], c[26], c[17:0], 1'b0);
      end
      check(32'(conv_busy), 32'h1);
      tally_and_finish();
   end

   // Nine frames take well under 0.2 ms; five times that means a hang.
   initial begin
      #1000000;
      err_total++;
      tally_and_finish();
   end
endmodule : adc_result_serial_readout_test
`default_nettype wire
